// ===== srap_defines.svh
`ifndef SRAP_DEFINES_SVH
`define SRAP_DEFINES_SVH
// Register addresses
`define SRAP_A_STATUS     16'hE502
`define SRAP_A_CONFIG     16'hE618
`define SRAP_A_LOCK       16'hEA00
`define SRAP_A_LASTOP     16'hEA01
`define SRAP_A_LASTADD    16'hE9FE
`define SRAP_A_LD8        16'hE7FD
`define SRAP_A_LD16       16'hE9FF
`define SRAP_A_LD32       16'hE5FF
`define SRAP_A_BURST_LO   16'hE50C
`define SRAP_A_BURST_HI   16'hE526
`define SRAP_ADDR_STEP    16'h0001
// Operation codes and fields
`define SRAP_OP_WRITE     8'hCA
`define SRAP_OP_READ      8'h35
`define SRAP_I2C_ADDR     7'h38
`define SRAP_RDY_BIT      17
`define SRAP_LOCK_BIT     0
`define SRAP_FUNC_RDY     2'h0
`define SRAP_SPI_TOGGLES  2'h3
// Register sizes in bytes
`define SRAP_NB8          3'h1
`define SRAP_NB16         3'h2
`define SRAP_NB32         3'h4
// Bit positions inside a frame
`define SRAP_BIT_ACK      4'h8
`define SRAP_BIT_END      4'h9
`define SRAP_SPI_RW_BIT   5'h07
`define SRAP_SPI_HDR_LAST 5'h17
`define SRAP_SPI_HDR_BITS 5'h18
`define SRAP_WORD_BITS    6'h20
// Ready pin timing
`define SRAP_CLK_MHZ      10
`define SRAP_RDY_DLY_NS   70
`define SRAP_RDY_LOW_US   10
`define SRAP_RDY_DLY_CYC  ((`SRAP_RDY_DLY_NS * `SRAP_CLK_MHZ + 999) / 1000)
`define SRAP_RDY_LOW_CYC  (`SRAP_RDY_LOW_US * `SRAP_CLK_MHZ)
`endif

// ===== srap_pkg.sv
package srap_pkg;
`include "srap_defines.svh"
   typedef enum logic [1:0] {I_IDLE, I_RX, I_TX, I_SKIP} srap_i2c_st_t;

   // Byte size of the register at an address
   function automatic logic [2:0] srap_reg_bytes(input logic [15:0] a);
      if (a >= `SRAP_A_BURST_LO && a <= `SRAP_A_BURST_HI)
         return `SRAP_NB32;
      case (a)
         `SRAP_A_STATUS, `SRAP_A_LD32:   return `SRAP_NB32;
         `SRAP_A_CONFIG, `SRAP_A_LASTADD,
         `SRAP_A_LD16:                   return `SRAP_NB16;
         default:                        return `SRAP_NB8;
      endcase
   endfunction : srap_reg_bytes
endpackage : srap_pkg

// ===== srap_top.sv
`timescale 1ns/1ps
`include "srap_defines.svh"
// Behaviour
// - Successful transfer stores accessed register address in 16-bit last-address register.
// - Last-operation register holds 0xCA after a write, 0x35 after a read.
// - Last-data register holds transfer data, seen at 8/16/32-bit view addresses.
// - Failed or incomplete transfers leave all three verification registers unchanged, except an I2C write stopped after at least one data byte.
// - Reading verification registers changes nothing and is not itself recorded.
// - I2C slave works up to 400 kHz; master stays at or below it.
// - I2C pins are only pulled low or released, never driven high.
// - Slave answers only to 7-bit address 0111000; write byte is 0x70.
// - I2C write: address byte, 16-bit pointer, 1/2/4 data bytes, all acknowledged, stop.
// - I2C read: set pointer, repeated start with 0x71, device returns bytes MSB first.
// - Burst reads may start at any register from 0xE50C to 0xE526.
// - Master acknowledge on a register's last byte advances pointer and streams next.
// - With function 00 the ready pin goes low after flag set, for 10 us.
// - SPI port is slave only, up to 2.5 MHz serial clock.
// - SPI samples on rising edges, shifts out on falling edges, MSB first.
// - SPI data output is released whenever the device is not sending.
// - Select rising mid-transfer aborts it and releases outputs at once.
// - Three select falls after reset choose SPI unless a write to 0xEA00 set bit 0 first; otherwise I2C, until reset.
// - SPI frame: command byte with read bit 0, 16-bit address, then data.
module srap_top #(
   parameter int RDY_DLY_CYC = `SRAP_RDY_DLY_CYC,   // Ready pin delay in cycles
   parameter int RDY_LOW_CYC = `SRAP_RDY_LOW_CYC    // Ready pin low time in cycles
) (
   input  wire logic        clk_i,                                  // System clock
   input  wire logic        rstn_i,                                 // Async reset, low
   input  wire logic        scl_sclk_i,                             // I2C SCL / SPI SCLK pin
   output logic             scl_o,                                  // SCL pull level
   output logic             scl_oe_o,                               // SCL pull enable
   input  wire logic        sda_mosi_i,                             // I2C SDA / SPI MOSI pin
   output logic             sda_o,                                  // SDA pull level
   output logic             sda_oe_o,                               // SDA pull enable
   input  wire logic        select_or_capture_strobe_pin_n_i,       // SPI select, low
   output logic             serial_out_or_capture_data_pin_o,       // SPI MISO level
   output logic             serial_out_or_capture_data_pin_oe_o,    // SPI MISO enable
   output logic             zero_cross_or_result_ready_pin_o,       // Ready pin, low active
   input  wire logic        result_ready_i,                         // Result update pulse
   output logic [15:0]      result_addr_o,                          // Result register address
   input  wire logic [31:0] result_data_i                           // Result register data
);
   // System domain state
   typedef struct packed {
      logic [2:0]          in1;       // Pin sync stage 1: ss, sda, scl
      logic [2:0]          in2;
      logic [2:0]          in3;
      logic [2:0]          t1;        // Event sync stage 1: rdone, wr, fetch
      logic [2:0]          t2;
      logic [2:0]          t3;
      logic                spi_mode;
      logic                locked;
      logic [1:0]          ss_falls;
      logic                flag;
      logic [15:0]         cfg;
      logic [7:0]          lock;
      logic [7:0]          last_operation_kind;
      logic [15:0]         last_addr;
      logic [31:0]         last_data;
      logic                pin;
      logic [11:0]         pcnt;
      srap_pkg::srap_i2c_st_t ist;
      logic [3:0]          bitc;
      logic [7:0]          sh;
      logic [1:0]          byten;
      logic                rw;
      logic                oe;
      logic [15:0]         ptr;
      logic [31:0]         wbuf;
      logic [2:0]          wbytes;
      logic [31:0]         txw;
      logic [7:0]          txsh;
      logic [1:0]          txi;
      logic                mack;
      logic [31:0]         rd_word;
      logic [15:0]         cur_addr;
      logic [15:0]         prev_addr;
      logic [31:0]         prev_data;
      logic                pend;
      logic [15:0]         res_addr;
   } srap_sys_t;

   // Link domain receive state, cleared by select high
   typedef struct packed {
      logic [4:0]          cnt;
      logic [31:0]         sh;
      logic                rw;
      logic [15:0]         addr;
      logic [5:0]          dcnt;
      logic                done;
   } srap_rx_t;

   // Link domain events toward the system domain
   typedef struct packed {
      logic                fetch_tgl;
      logic                wr_tgl;
      logic                rdone_tgl;
      logic [15:0]         fetch_addr;
      logic [15:0]         wr_addr;
      logic [31:0]         wr_data;
   } srap_ev_t;

   // Link domain transmit state, falling edge
   typedef struct packed {
      logic [31:0]         osh;
      logic                miso;
      logic                oe;
   } srap_tx_t;

   srap_sys_t s, next_s;
   srap_rx_t  rx, next_rx;
   srap_ev_t  ev, next_ev;
   srap_tx_t  tx, next_tx;
   logic      spi_rst_n;
   logic      scl_hi, scl_rise, scl_fall, sda_rise, sda_fall, ss_fall;
   logic [2:0] evt;

   // Verification registers never record their own reads
   function automatic logic is_verif(input logic [15:0] a);
      return a == `SRAP_A_LASTOP || a == `SRAP_A_LASTADD || a == `SRAP_A_LD8 ||
             a == `SRAP_A_LD16 || a == `SRAP_A_LD32;
   endfunction : is_verif

   // Register read decode, shared by both ports
   function automatic logic [31:0] rd_reg(input srap_sys_t st, input logic [15:0] a,
                                          input logic [31:0] rdat);
      logic [31:0] v;
      v = 32'h0000_0000;
      case (a)
         `SRAP_A_STATUS:  v[`SRAP_RDY_BIT] = st.flag;
         `SRAP_A_CONFIG:  v[15:0] = st.cfg;
         `SRAP_A_LOCK:    v[7:0] = st.lock;
         `SRAP_A_LASTOP:  v[7:0] = st.last_operation_kind;
         `SRAP_A_LASTADD: v[15:0] = st.last_addr;
         `SRAP_A_LD8:     v[7:0] = st.last_data[7:0];
         `SRAP_A_LD16:    v[15:0] = st.last_data[15:0];
         `SRAP_A_LD32:    v = st.last_data;
         default:
         begin
            if (a >= `SRAP_A_BURST_LO && a <= `SRAP_A_BURST_HI)
               v = rdat;
         end
      endcase
      return v;
   endfunction : rd_reg

   // Record one completed transfer
   function automatic srap_sys_t rec(input srap_sys_t st, input logic [7:0] op,
                                     input logic [15:0] a, input logic [31:0] d);
      srap_sys_t r;
      r = st;
      if (!(op == `SRAP_OP_READ && is_verif(a)))
      begin
         r.last_addr = a;
         r.last_operation_kind = op;
         r.last_data = d;
      end
      return r;
   endfunction : rec

   // Commit a completed register write
   function automatic srap_sys_t wr_reg(input srap_sys_t st, input logic [15:0] a,
                                        input logic [31:0] d);
      srap_sys_t r;
      r = st;
      case (a)
         `SRAP_A_STATUS:
         begin
            if (d[`SRAP_RDY_BIT])
               r.flag = 1'h0;
         end
         `SRAP_A_CONFIG:  r.cfg = d[15:0];
         `SRAP_A_LOCK:
         begin
            r.lock = d[7:0];
            if (st.spi_mode || d[`SRAP_LOCK_BIT])
               r.locked = 1'h1;
         end
         default:         r.locked = r.locked;
      endcase
      return rec(r, `SRAP_OP_WRITE, a, d);
   endfunction : wr_reg

   // Byte of a register word, most significant first
   function automatic logic [7:0] sel_byte(input logic [31:0] w, input logic [2:0] nb,
                                           input logic [1:0] idx);
      logic [2:0] k;
      k = nb - 3'h1 - {1'h0, idx};
      return 8'(w >> {k, 3'h0});
   endfunction : sel_byte

   // Pin edges from the second sync stage onward
   assign scl_hi   = s.in2[0];
   assign scl_rise = s.in2[0] & ~s.in3[0];
   assign scl_fall = ~s.in2[0] & s.in3[0];
   assign sda_rise = s.in2[1] & ~s.in3[1];
   assign sda_fall = ~s.in2[1] & s.in3[1];
   assign ss_fall  = ~s.in2[2] & s.in3[2];
   assign evt      = s.t2 ^ s.t3;

   // System domain next state
   always_comb
   begin
      next_s = s;
      next_s.in1 = {select_or_capture_strobe_pin_n_i, sda_mosi_i, scl_sclk_i};
      next_s.in2 = s.in1;
      next_s.in3 = s.in2;
      next_s.t1 = {ev.rdone_tgl, ev.wr_tgl, ev.fetch_tgl};
      next_s.t2 = s.t1;
      next_s.t3 = s.t2;
      // port choice by select falls until locked
      if (!s.locked && !s.spi_mode && ss_fall)
      begin
         next_s.ss_falls = s.ss_falls + 2'h1;
         if (next_s.ss_falls == `SRAP_SPI_TOGGLES)
            next_s.spi_mode = 1'h1;
      end
      if (!s.spi_mode)
      begin
         if (sda_fall && scl_hi)
         begin
            next_s.ist = srap_pkg::I_RX;
            next_s.bitc = 4'h0;
            next_s.byten = 2'h0;
            next_s.wbytes = 3'h0;
            next_s.wbuf = 32'h0000_0000;
            next_s.oe = 1'h0;
         end
         else if (sda_rise && scl_hi)
         begin
            // write commits only at stop after data bytes
            if (s.ist == srap_pkg::I_RX && !s.rw && s.wbytes != 3'h0)
               next_s = wr_reg(next_s, s.ptr, s.wbuf);
            next_s.ist = srap_pkg::I_IDLE;
            next_s.oe = 1'h0;
         end
         else if (s.ist == srap_pkg::I_RX || s.ist == srap_pkg::I_TX)
         begin
            if (scl_rise && s.bitc < `SRAP_BIT_ACK)
            begin
               next_s.sh = {s.sh[6:0], s.in2[1]};
               next_s.bitc = s.bitc + 4'h1;
            end
            else if (scl_rise && s.bitc == `SRAP_BIT_ACK)
            begin
               next_s.bitc = `SRAP_BIT_END;
               if (s.ist == srap_pkg::I_TX)
               begin
                  next_s.mack = ~s.in2[1];
                  if (s.txi == 2'(srap_pkg::srap_reg_bytes(s.ptr) - 3'h1))
                  begin
                     next_s = rec(next_s, `SRAP_OP_READ, s.ptr, s.txw);
                     if (!s.in2[1])
                        next_s.ptr = s.ptr + `SRAP_ADDR_STEP;
                  end
               end
            end
            else if (scl_fall && s.bitc == `SRAP_BIT_ACK)
            begin
               next_s.oe = 1'h0;
               if (s.ist == srap_pkg::I_RX)
               begin
                  next_s.oe = 1'h1;
                  next_s.byten = (s.byten == 2'h3) ? s.byten : s.byten + 2'h1;
                  case (s.byten)
                     2'h0:
                     begin
                        next_s.rw = s.sh[0];
                        if (s.sh[7:1] != `SRAP_I2C_ADDR)
                        begin
                           next_s.oe = 1'h0;
                           next_s.ist = srap_pkg::I_SKIP;
                        end
                     end
                     2'h1:    next_s.ptr[15:8] = s.sh;
                     2'h2:    next_s.ptr[7:0] = s.sh;
                     default:
                     begin
                        next_s.wbuf = {s.wbuf[23:0], s.sh};
                        if (s.wbytes != `SRAP_NB32)
                           next_s.wbytes = s.wbytes + 3'h1;
                     end
                  endcase
               end
            end
            else if (scl_fall && s.bitc == `SRAP_BIT_END)
            begin
               next_s.bitc = 4'h0;
               next_s.oe = 1'h0;
               // read stage loads the word at the pointer
               if (s.ist == srap_pkg::I_RX && s.rw)
               begin
                  next_s.ist = srap_pkg::I_TX;
                  next_s.txw = rd_reg(s, s.ptr, result_data_i);
                  next_s.txi = 2'h0;
               end
               else if (s.ist == srap_pkg::I_TX && s.mack)
               begin
                  if (s.txi == 2'(srap_pkg::srap_reg_bytes(s.ptr) - 3'h1))
                  begin
                     next_s.txw = rd_reg(s, s.ptr, result_data_i);
                     next_s.txi = 2'h0;
                  end
                  else
                     next_s.txi = s.txi + 2'h1;
               end
               else if (s.ist == srap_pkg::I_TX)
                  next_s.ist = srap_pkg::I_SKIP;
               if (next_s.ist == srap_pkg::I_TX)
               begin
                  next_s.txsh = sel_byte(next_s.txw, srap_pkg::srap_reg_bytes(s.ptr), next_s.txi);
                  // data bit 0 pulls low, 1 releases
                  next_s.oe = ~next_s.txsh[7];
                  next_s.txsh = {next_s.txsh[6:0], 1'h0};
               end
            end
            else if (scl_fall && s.ist == srap_pkg::I_TX)
            begin
               next_s.oe = ~s.txsh[7];
               next_s.txsh = {s.txsh[6:0], 1'h0};
            end
         end
         next_s.res_addr = next_s.ptr;
      end
      else
      begin
         // SPI word fetch, write commit and read completion
         if (evt[0])
         begin
            next_s.prev_addr = s.cur_addr;
            next_s.prev_data = s.rd_word;
            next_s.cur_addr = ev.fetch_addr;
            next_s.pend = 1'h1;
         end
         if (s.pend)
         begin
            next_s.rd_word = rd_reg(s, s.cur_addr, result_data_i);
            next_s.pend = 1'h0;
         end
         if (evt[1])
            next_s = wr_reg(next_s, ev.wr_addr, ev.wr_data);
         if (evt[2])
            next_s = rec(next_s, `SRAP_OP_READ, s.prev_addr, s.prev_data);
         next_s.res_addr = next_s.cur_addr;
      end
      // Flag set wins over a clearing write
      if (result_ready_i)
         next_s.flag = 1'h1;
      // ready pin low pulse after flag sets
      if (s.pcnt != 12'h000)
         next_s.pcnt = s.pcnt - 12'h001;
      if (result_ready_i && s.cfg[1:0] == `SRAP_FUNC_RDY)
         next_s.pcnt = 12'(RDY_DLY_CYC + RDY_LOW_CYC);
      next_s.pin = !(next_s.pcnt != 12'h000 && next_s.pcnt <= 12'(RDY_LOW_CYC));
   end

   // System domain registers
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         s <= '0;
         s.in1 <= 3'h7;
         s.in2 <= 3'h7;
         s.in3 <= 3'h7;
         s.pin <= 1'h1;
      end
      else
         s <= next_s;
   end

   // select high holds the link receive and transmit logic cleared
   assign spi_rst_n = rstn_i & ~select_or_capture_strobe_pin_n_i;

   // Link receive and events, rising edge
   always_comb
   begin
      next_rx = rx;
      next_ev = ev;
      // sample on rising edge, MSB first
      next_rx.sh = {rx.sh[30:0], sda_mosi_i};
      if (rx.cnt < `SRAP_SPI_HDR_BITS)
      begin
         next_rx.cnt = rx.cnt + 5'h01;
         if (rx.cnt == `SRAP_SPI_RW_BIT)
            next_rx.rw = sda_mosi_i;
         if (rx.cnt == `SRAP_SPI_HDR_LAST)
         begin
            next_rx.addr = next_rx.sh[15:0];
            if (rx.rw)
            begin
               next_ev.fetch_tgl = ~ev.fetch_tgl;
               next_ev.fetch_addr = next_rx.sh[15:0];
            end
         end
      end
      else if (!rx.done)
      begin
         next_rx.dcnt = rx.dcnt + 6'h01;
         // Prefetch the following register for a burst
         if (rx.rw && rx.dcnt == 6'h00)
         begin
            next_ev.fetch_tgl = ~ev.fetch_tgl;
            next_ev.fetch_addr = rx.addr + `SRAP_ADDR_STEP;
         end
         if (next_rx.dcnt == {srap_pkg::srap_reg_bytes(rx.addr), 3'h0})
         begin
            if (!rx.rw)
            begin
               next_ev.wr_tgl = ~ev.wr_tgl;
               next_ev.wr_addr = rx.addr;
               next_ev.wr_data = next_rx.sh & ~(32'hFFFF_FFFF << next_rx.dcnt);
               next_rx.done = 1'h1;
            end
            else
            begin
               next_ev.rdone_tgl = ~ev.rdone_tgl;
               next_rx.dcnt = 6'h00;
               next_rx.addr = rx.addr + `SRAP_ADDR_STEP;
            end
         end
      end
   end

   always_ff @(posedge scl_sclk_i or negedge spi_rst_n)
   begin
      if (!spi_rst_n)
         rx <= '0;
      else
         rx <= next_rx;
   end

   // Events survive select so toggles never jump
   always_ff @(posedge scl_sclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         ev <= '0;
      else
         ev <= next_ev;
   end

   // Link transmit, falling edge; read word is held still by the system side
   always_comb
   begin
      next_tx = tx;
      if (rx.rw && rx.cnt == `SRAP_SPI_HDR_BITS && rx.dcnt == 6'h00 && !rx.done)
      begin
         next_tx.osh = s.rd_word << (`SRAP_WORD_BITS - {srap_pkg::srap_reg_bytes(rx.addr), 3'h0});
         next_tx.miso = next_tx.osh[31];
         next_tx.osh = {next_tx.osh[30:0], 1'h0};
         next_tx.oe = 1'h1;
      end
      else if (tx.oe)
      begin
         next_tx.miso = tx.osh[31];
         next_tx.osh = {tx.osh[30:0], 1'h0};
      end
   end

   always_ff @(negedge scl_sclk_i or negedge spi_rst_n)
   begin
      if (!spi_rst_n)
         tx <= '0;
      else
         tx <= next_tx;
   end

   // Outputs
   assign scl_o                               = 1'h0;
   assign scl_oe_o                            = 1'h0;
   assign sda_o                               = 1'h0;
   assign sda_oe_o                            = s.oe;
   assign serial_out_or_capture_data_pin_o    = tx.miso;
   assign serial_out_or_capture_data_pin_oe_o = tx.oe;
   assign zero_cross_or_result_ready_pin_o    = s.pin;
   assign result_addr_o                       = s.res_addr;
endmodule : srap_top

// ===== srap_monitor.sv
`timescale 1ns/1ps
module srap_monitor #(
   parameter int RDY_DLY_CYC = 1,   // Ready pin delay
   parameter int RDY_LOW_CYC = 100  // Ready pin low time
) (
   input wire logic clk_i,                                // System clock
   input wire logic rstn_i,                               // Async reset, low
   input wire logic scl_sclk_i,                           // Clock pin level
   input wire logic scl_oe_o,                             // Clock pull enable
   input wire logic sda_o,                                // Data pull level
   input wire logic sda_oe_o,                             // Data pull enable
   input wire logic select_or_capture_strobe_pin_n_i,     // Select, low
   input wire logic serial_out_or_capture_data_pin_oe_o,  // Serial out enable
   input wire logic zero_cross_or_result_ready_pin_o,     // Ready pin
   input wire logic result_ready_i                        // Result pulse
);
   localparam int RDY_FALL = RDY_DLY_CYC + 1;
   logic        pin;
   logic [15:0] low_cnt;
   assign pin = zero_cross_or_result_ready_pin_o;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // Counts cycles with the ready pin low
   always_ff @(posedge clk_i or negedge rstn_i)
      if (!rstn_i)
         low_cnt <= 16'h0000;
      else
         low_cnt <= pin ? 16'h0000 : low_cnt + 16'h0001;
   sequence s_low_stretch;
      !pin [*4];
   endsequence
   a_ready_cause: assert property ($fell(pin) |-> $past(result_ready_i, RDY_FALL))
      else $error("ready pin fell without a result pulse");
   a_ready_hold: assert property ($fell(pin) |-> s_low_stretch)
      else $error("ready pin low too briefly");
   a_ready_length: assert property ($rose(pin) |-> low_cnt == RDY_LOW_CYC)
      else $error("ready pin low time wrong");
   a_scl_not_driven: assert property (!scl_oe_o)
      else $error("clock pin pulled by device");
   a_sda_open_drain: assert property (sda_oe_o |-> !sda_o)
      else $error("data pin driven high");
   a_sda_pull_timing: assert property ($rose(sda_oe_o) |-> !scl_sclk_i && !$past(scl_sclk_i, 2))
      else $error("data pull began while clock high");
   a_sda_free_timing: assert property ($fell(sda_oe_o) |-> !scl_sclk_i && !$past(scl_sclk_i, 2))
      else $error("data release while clock high");
   a_out_hiz_idle: assert property (select_or_capture_strobe_pin_n_i |-> !serial_out_or_capture_data_pin_oe_o)
      else $error("serial out driven while deselected");
endmodule : srap_monitor
bind srap_top srap_monitor #(.RDY_DLY_CYC(RDY_DLY_CYC), .RDY_LOW_CYC(RDY_LOW_CYC)) mon (.clk_i, .rstn_i,
   .scl_sclk_i, .scl_oe_o, .sda_o, .sda_oe_o, .select_or_capture_strobe_pin_n_i,
   .serial_out_or_capture_data_pin_oe_o, .zero_cross_or_result_ready_pin_o, .result_ready_i);

// ===== srap_host.sv
`timescale 1ns/1ps
module srap_host #(
   // half period keeps clock below 400 kHz
   parameter int H = 13  // Clock half period in cycles
) (
   input  wire logic clk_i,  // System clock
   input  wire logic sda_i,  // Resolved data level
   output logic      scl_o,  // Clock, 1 = released
   output logic      sda_o   // Data, 1 = released
);
   initial
   begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic hw(input int n);
      repeat (n) @(posedge clk_i);
   endtask : hw
   // Start or repeated start, data falls with clock high
   task automatic start();
      hw(3); sda_o <= 1'b1; hw(H); scl_o <= 1'b1; hw(H); sda_o <= 1'b0; hw(H); scl_o <= 1'b0;
   endtask : start
   task automatic stop();
      hw(3); sda_o <= 1'b0; hw(H); scl_o <= 1'b1; hw(H); sda_o <= 1'b1; hw(H);
   endtask : stop
   // Data settles after the clock fall has passed the sync flops
   task automatic bitx(input logic b, output logic r);
      hw(3); sda_o <= b; hw(H); scl_o <= 1'b1; hw(H); r = sda_i; scl_o <= 1'b0;
   endtask : bitx
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(d[i], r);
      bitx(1'b1, r);
      ack = ~r;
   endtask : wbyte
   // acknowledge all but the final byte
   task automatic rbyte(input logic mack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin bitx(1'b1, r); d[i] = r; end
      bitx(~mack, r);
   endtask : rbyte
   task automatic wr(input logic [15:0] a, input logic [31:0] d, input int nb, output logic ok);
      logic k;
      start(); wbyte(8'h70, ok); wbyte(a[15:8], k); ok &= k; wbyte(a[7:0], k); ok &= k;
      for (int i = nb - 1; i >= 0; i--) begin wbyte(d[8*i+:8], k); ok &= k; end
      stop();
   endtask : wr
   task automatic rd(input logic [15:0] a, input int nb, output logic [63:0] q);
      logic k;
      logic [7:0] b;
      q = '0; start(); wbyte(8'h70, k); wbyte(a[15:8], k); wbyte(a[7:0], k); start(); wbyte(8'h71, k);
      for (int i = nb - 1; i >= 0; i--) begin rbyte(i != 0, b); q = {q[55:0], b}; end
      stop();
   endtask : rd
endmodule : srap_host

// ===== test_serial_register_access_port.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin errors++; \
   $display("wrong value %s expected %h seen %h", n, e, s); end end
module test_serial_register_access_port;
   localparam int LOWC = 5;
   logic        clk_i = 1'b0, rstn_i = 1'b0, rdy = 1'b0, k, h_scl, h_sda, scl_oe, sda_oe, pin, ss = 1'b1, miso;
   logic [15:0] raddr, d, lfsr = 16'h002B;
   logic [63:0] q;
   int          errors = 0, num_checks = 0;
   wire logic   scl_w = h_scl & ~scl_oe;
   wire logic   sda_w = h_sda & ~sda_oe;
   function automatic logic [15:0] nxt(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : nxt
   function automatic logic [31:0] rexp(input logic [15:0] a);
      return {~a, a};
   endfunction : rexp
   srap_host h (.clk_i, .sda_i(sda_w), .scl_o(h_scl), .sda_o(h_sda));
   srap_top #(.RDY_LOW_CYC(LOWC)) dut (.clk_i, .rstn_i, .scl_sclk_i(scl_w), .scl_o(), .scl_oe_o(scl_oe),
      .sda_mosi_i(sda_w), .sda_o(), .sda_oe_o(sda_oe), .select_or_capture_strobe_pin_n_i(ss),
      .serial_out_or_capture_data_pin_o(miso), .serial_out_or_capture_data_pin_oe_o(),
      .zero_cross_or_result_ready_pin_o(pin), .result_ready_i(rdy), .result_addr_o(raddr),
      .result_data_i(rexp(raddr)));
   // Link frame, MSB first, clock held high for the word fetch
   task automatic spi(input logic [39:0] f, output logic [15:0] r);
      repeat (4) @(posedge clk_i);
      ss <= 1'b0;
      for (int i = 39; i >= 0; i--)
      begin
         repeat (i == 15 ? 12 : 4) @(posedge clk_i);
         h.sda_o <= f[i];
         h.scl_o <= 1'b0;
         repeat (4) @(posedge clk_i);
         h.scl_o <= 1'b1;
         r = {r[14:0], miso};
      end
      repeat (4) @(posedge clk_i);
      ss <= 1'b1;
   endtask : spi
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish
   initial
      forever #50 clk_i = ~clk_i;
   // Hang guard
   initial
   begin
      repeat (90000) @(posedge clk_i);
      errors++;
      tally_and_finish();
   end
   // Main sequence
   initial
   begin
      repeat (20) @(posedge clk_i);
      rstn_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      for (int t = 0; t < 2; t++)
      begin
         lfsr = nxt(lfsr);
         d = lfsr & 16'hFFFC;
         h.wr(16'hE618, {16'h0000, d}, 2, k); `CHK("write ack", 1'b1, k)
         h.rd(16'hEA01, 1, q); `CHK("op after write", 8'hCA, q[7:0])
         h.rd(16'hE9FE, 2, q); `CHK("last address", 16'hE618, q[15:0])
         h.rd(16'hE9FF, 2, q); `CHK("last data 16", d, q[15:0])
         h.rd(16'hE618, 2, q); `CHK("readback", d, q[15:0])
         h.rd(16'hEA01, 1, q); `CHK("op after read", 8'h35, q[7:0])
         h.rd(16'hE5FF, 4, q); `CHK("last data 32", {16'h0000, d}, q[31:0])
         h.rd(16'hE7FD, 1, q); `CHK("last data 8", d[7:0], q[7:0])
      end
      h.rd(16'hE50C, 8, q); `CHK("burst", {rexp(16'hE50C), rexp(16'hE50D)}, q)
      h.rd(16'hE9FE, 2, q); `CHK("burst address", 16'hE50D, q[15:0])
      @(posedge clk_i);
      rdy <= 1'b1;
      @(posedge clk_i);
      rdy <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1 `CHK("ready low", 1'b0, pin)
      repeat (LOWC) @(posedge clk_i);
      #1 `CHK("ready high", 1'b1, pin)
      h.rd(16'hE502, 4, q); `CHK("ready flag", 1'b1, q[17])
      h.start(); h.wbyte(8'h72, k); `CHK("foreign ack", 1'b0, k)
      h.wbyte(8'hE6, k); h.wbyte(8'h18, k); h.wbyte(8'h00, k); h.stop();
      h.wr(16'hE618, 32'h0000_0000, 0, k);
      h.rd(16'hEA01, 1, q); `CHK("op kept", 8'h35, q[7:0])
      h.rd(16'hE618, 2, q); `CHK("config kept", d, q[15:0])
      // Third select fall picks the link port
      d = nxt(lfsr);
      repeat (3) spi({8'h00, 16'hE618, d}, q[15:0]);
      spi({8'h01, 16'hE618, 16'h0000}, q[15:0]); `CHK("link readback", d, q[15:0])
      tally_and_finish();
   end
endmodule : test_serial_register_access_port
